/* hdl/rpsf_pkg.sv */
// rpsf_pkg: constants shared by the pixel serializer front end
// assumes a 200 mhz system clock sampling all pins
package rpsf_pkg;
   // colour channel width and table depth
   localparam int CHAN_W     = 8;
   localparam int LUT_DEPTH  = 256;
   localparam int LUT_AW     = 8;
   // serial lanes and word per pixel (r,g,b,vs,hs,fs)
   localparam int LANES      = 3;
   localparam int WORD_W     = 28;
   localparam int SLICES     = 10;
   localparam logic [3:0] SLICE_LAST = 4'h9;
   // pixel clock watchdog: stop time in ns and derived cycles
   localparam int CLK_NS     = 5;
   localparam int STOP_NS    = 2000;
   localparam int STOP_CYC   = STOP_NS / CLK_NS;
   localparam logic [9:0] STOP_CNT = 10'(STOP_CYC);
   // link clock divider last count; half period is 4 system cycles
   localparam logic [2:0] LCLK_HALF = 3'h3;
   // spi command: bit 23 read, 22:21 target, 15:8 addr, 7:0 data
   localparam int CMD_W      = 24;
   localparam int CMD_RD     = 23;
   localparam logic [1:0] TGT_CFG = 2'h0;
   localparam logic [1:0] TGT_RED = 2'h1;
   localparam logic [1:0] TGT_GRN = 2'h2;
   localparam logic [1:0] TGT_BLU = 2'h3;
   // configuration bit positions and reset value
   localparam int CFG_LUT    = 0;
   localparam int CFG_DITH   = 1;
   localparam int CFG_APD    = 2;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [4:0] SPI_LAST = 5'h17;
endpackage

/* hdl/rpsf_lut.sv */
// rpsf_lut: one colour correction table, 256 by 8
// assumes writes come from the spi side on the same clock
`timescale 1ns/1ps
module rpsf_lut (
   // clock
   input  wire logic                       clk_sys,
   // write port
   input  wire logic                       wr_en,
   input  wire logic [rpsf_pkg::LUT_AW-1:0] wr_addr,
   input  wire logic [rpsf_pkg::CHAN_W-1:0] wr_data,
   // read port, one cycle latency
   input  wire logic [rpsf_pkg::LUT_AW-1:0] rd_addr,
   output logic      [rpsf_pkg::CHAN_W-1:0] rd_data
);
   // table storage, no reset so contents survive sleep
   logic [rpsf_pkg::CHAN_W-1:0] mem [rpsf_pkg::LUT_DEPTH];

   // synchronous write and read
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

/* hdl/rpsf_buf.sv */
// rpsf_buf: two-entry valid/ready buffer
// assumes both sides on clk_sys
`timescale 1ns/1ps
module rpsf_buf (
   // clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   // fill side
   input  wire logic                          in_valid,
   output logic                               in_ready,
   input  wire logic [rpsf_pkg::WORD_W-1:0]   in_data,
   // drain side
   output logic                               out_valid,
   input  wire logic                          out_ready,
   output logic      [rpsf_pkg::WORD_W-1:0]   out_data
);
   logic [rpsf_pkg::WORD_W-1:0] slot_r [2]; // storage
   logic                        wp_r;       // write pointer
   logic                        rp_r;       // read pointer
   logic [1:0]                  cnt_r;      // fill level
   logic                        push;
   logic                        pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = slot_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointers and level
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         if (push) wp_r <= ~wp_r;
         if (pop)  rp_r <= ~rp_r;
         cnt_r <= cnt_r + 2'(push) - 2'(pop);
      end
   end

   // data slots
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         slot_r[wp_r] <= in_data;
      end
   end
endmodule

/* hdl/rpsf_top.sv */
// rpsf_top: rgb capture, lookup, dither, serial lanes, spi config
// assumes all pins asynchronous to clk_sys; pixel clock well below
// clk_sys/4, spi clock likewise; line drivers are outside
`timescale 1ns/1ps
// Contract
// R01: spi live only if selected, awake, clock static
// R02: data pin input unless spi read
// R03: chip select high makes pin hsync
// R04: sleep clears settings, keeps table; cfg_r is cleared only for power_down_n low, auto sleep (R13) keeps it
// R05: power_down_n high wakes the device
// R06: sample video on pixel clock rise
// R07: three 8-bit channels, bit 7 msb
// R08: vertical sync marks dither frame start
// R09: vertical sync passed unaltered
// R10: optional 24 to 18 bit dither
// R11: three 256x8 tables indexed by colour
// R12: host loads and enables table via spi
// R13: optional auto sleep on stopped clock
// R14: frame sequence resyncs after error
// R15: three data lanes plus link clock
// R16: test mode must be held low
// R17: only data-enable pixels are active video
module rpsf_top (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // video pins
   input  wire logic        pixel_clk,
   input  wire logic [7:0]  red_in,
   input  wire logic [7:0]  green_in,
   input  wire logic [7:0]  blue_in,
   input  wire logic        vertical_sync,
   input  wire logic        video_data_enable,
   // configuration pins
   input  wire logic        cfg_chip_select_n,
   input  wire logic        cfg_spi_clk,
   input  wire logic        cfg_data_or_hsync_pin_i,
   output logic             cfg_data_or_hsync_pin_o,
   output logic             cfg_data_or_hsync_pin_oe,
   input  wire logic        power_down_n,
   input  wire logic        test_mode_select,
   input  wire logic        reserved_tie_high,
   // link error report from the far end
   input  wire logic        link_error,
   // serial link
   output logic [2:0]       serial_data_lanes,
   output logic             serial_link_clock,
   // status
   output logic             sleeping,
   output logic             frame_sync_err
);
   // two-flop synchronisers for every pin input
   localparam int SW = 34;
   // reset image: reserved pin idles high, so no false wiring flag
   localparam logic [SW-1:0] SYNC_RST = 34'h0_0000_0001;
   logic [SW-1:0] raw;
   logic [SW-1:0] s1_r;
   logic [SW-1:0] s2_r;
   assign raw = {pixel_clk, red_in, green_in, blue_in, vertical_sync,
                 video_data_enable, cfg_chip_select_n, cfg_spi_clk,
                 cfg_data_or_hsync_pin_i, power_down_n, link_error,
                 test_mode_select, reserved_tie_high};
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= SYNC_RST;
         s2_r <= SYNC_RST;
      end
      else
      begin
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end

   // synchronised names
   logic       pclk_s, vs_s, de_s, cs_n_s, sck_s, sda_s, pd_n_s, err_s;
   logic [7:0] r_s, g_s, b_s;
   logic       tm_s, res_s, tm_bad_s;
   assign {pclk_s, r_s, g_s, b_s, vs_s, de_s, cs_n_s, sck_s, sda_s,
           pd_n_s, err_s, tm_s, res_s} = s2_r;
   // test pin high or reserved pin low is a wiring fault
   assign tm_bad_s = tm_s || !res_s;                 // R16

   // edge detection state on synchronised copies
   logic pclk_d_r;  // previous pixel clock
   logic sck_d_r;   // previous spi clock
   logic pclk_rise;
   logic sck_rise;
   logic sck_fall;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pclk_d_r <= 1'b0;
         sck_d_r  <= 1'b0;
      end
      else
      begin
         pclk_d_r <= pclk_s;
         sck_d_r  <= sck_s;
      end
   end
   assign pclk_rise = pclk_s && !pclk_d_r; // R06
   assign sck_rise  = sck_s && !sck_d_r;
   assign sck_fall  = !sck_s && sck_d_r;

   // pixel clock watchdog: static means no edge for STOP_CNT cycles
   logic [9:0] idle_r;
   logic       pclk_static;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         idle_r <= '0;
      else if (pclk_s != pclk_d_r)
         idle_r <= '0;
      else if (idle_r != rpsf_pkg::STOP_CNT)
         idle_r <= idle_r + 10'h001;
   end
   assign pclk_static = (idle_r == rpsf_pkg::STOP_CNT);

   // configuration register, cleared while power_down_n is low
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic       cfg_we;
   logic       asleep;
   // sleep on pin low, or on stopped clock when auto mode is set
   assign asleep = !pd_n_s ||                                      // R04
                   (cfg_r[rpsf_pkg::CFG_APD] && pclk_static);       // R13
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cfg_r <= rpsf_pkg::CFG_RST;
      else if (!pd_n_s)
         cfg_r <= rpsf_pkg::CFG_RST;  // R04
      else if (cfg_we)
         cfg_r <= cfg_nxt;            // R12
   end

   // spi port enable
   logic spi_en;
   assign spi_en = !cs_n_s && pd_n_s && pclk_static; // R01

   // spi shifter: 24 bits msb first, sampled on rise
   logic [rpsf_pkg::CMD_W-1:0] sh_r;
   logic [4:0]                 bit_r;
   logic                       rd_r;     // read transaction
   logic [7:0]                 rd_sh_r;  // read data shifter
   logic                       done;
   logic [rpsf_pkg::CMD_W-1:0] word;
   assign word = {sh_r[rpsf_pkg::CMD_W-2:0], sda_s};
   assign done = spi_en && sck_rise && (bit_r == rpsf_pkg::SPI_LAST);
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_r  <= '0;
         bit_r <= '0;
         rd_r  <= 1'b0;
      end
      else if (!spi_en)
      begin
         bit_r <= '0;                 // R01
         rd_r  <= 1'b0;
      end
      else if (sck_rise)
      begin
         sh_r  <= word;
         bit_r <= done ? 5'h00 : bit_r + 5'h01;
         // read flag known once the first bit is in
         if (bit_r == 5'h00)
            rd_r <= sda_s;
         else if (done)
            rd_r <= 1'b0;
      end
   end

   // decode completed commands
   logic [1:0] tgt;
   logic [7:0] addr;
   logic [7:0] wdat;
   logic [2:0] lut_we;
   assign tgt     = word[rpsf_pkg::CMD_RD-1 -: 2];
   assign addr    = word[15:8];
   assign wdat    = word[7:0];
   assign cfg_we  = done && !word[rpsf_pkg::CMD_RD] &&
                    tgt == rpsf_pkg::TGT_CFG;
   assign cfg_nxt = wdat;
   // table write strobes, one per colour
   assign lut_we[0] = done && !word[rpsf_pkg::CMD_RD] &&
                      tgt == rpsf_pkg::TGT_RED;
   assign lut_we[1] = done && !word[rpsf_pkg::CMD_RD] &&
                      tgt == rpsf_pkg::TGT_GRN;
   assign lut_we[2] = done && !word[rpsf_pkg::CMD_RD] &&
                      tgt == rpsf_pkg::TGT_BLU;

   // read data: configuration is returned, changed on falling clock
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_sh_r                  <= '0;
         cfg_data_or_hsync_pin_o  <= 1'b0;
         cfg_data_or_hsync_pin_oe <= 1'b0;
      end
      else
      begin
         if (spi_en && sck_fall && bit_r == 5'h10)
            rd_sh_r <= cfg_r;
         else if (spi_en && sck_fall)
            rd_sh_r <= {rd_sh_r[6:0], 1'b0};
         cfg_data_or_hsync_pin_o <= rd_sh_r[7];
         // drive only in the data phase of a read
         cfg_data_or_hsync_pin_oe <= spi_en && rd_r &&
                                     bit_r >= 5'h10;           // R02
      end
   end

   // video capture on pixel clock rise
   logic [7:0] r_cap_r, g_cap_r, b_cap_r; // bit 7 msb
   logic       vs_cap_r, hs_cap_r, de_cap_r, cap_v_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {r_cap_r, g_cap_r, b_cap_r} <= '0;
         {vs_cap_r, hs_cap_r, de_cap_r, cap_v_r} <= '0;
      end
      else
      begin
         cap_v_r <= pclk_rise && !asleep;
         if (pclk_rise)
         begin
            r_cap_r  <= r_s;                       // R07
            g_cap_r  <= g_s;
            b_cap_r  <= b_s;
            vs_cap_r <= vs_s;
            hs_cap_r <= cs_n_s ? sda_s : 1'b0;     // R03
            de_cap_r <= de_s;
         end
      end
   end

   // colour tables, looked up one cycle after capture
   logic [23:0] lut_out;
   logic [23:0] cap_rgb;
   assign cap_rgb = {r_cap_r, g_cap_r, b_cap_r};
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++)
      begin : g_lut
         rpsf_lut u_lut (                                    // R11
            .clk_sys (clk_sys),
            .wr_en   (lut_we[ch]),
            .wr_addr (addr),
            .wr_data (wdat),
            .rd_addr (cap_rgb[23-8*ch -: 8]),
            .rd_data (lut_out[23-8*ch -: 8])
         );
      end
   endgenerate

   // align sideband with table latency
   logic [23:0] raw_d_r;
   logic        vs_d_r, hs_d_r, de_d_r, v_d_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         raw_d_r <= '0;
         {vs_d_r, hs_d_r, de_d_r, v_d_r} <= '0;
      end
      else
      begin
         raw_d_r <= cap_rgb;
         vs_d_r  <= vs_cap_r;
         hs_d_r  <= hs_cap_r;
         de_d_r  <= de_cap_r;
         v_d_r   <= cap_v_r;
      end
   end

   // choose corrected or raw colour, then dither
   logic [23:0] col;
   logic [23:0] dith;
   logic [1:0]  phase_r;  // frame ordered dither phase, steps per active pixel
   logic        vs_prev_r;
   assign col = cfg_r[rpsf_pkg::CFG_LUT] ? lut_out : raw_d_r;  // R12
   generate
      for (ch = 0; ch < 3; ch++)
      begin : g_dith
         logic [8:0] sum;
         assign sum = {1'b0, col[23-8*ch -: 8]} + 9'(phase_r);
         // saturate then drop two lsbs
         assign dith[23-8*ch -: 8] = sum[8] ? 8'hfc : {sum[7:2], 2'b00};
      end
   endgenerate

   // dither phase restarts on each vertical sync rise
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_r   <= '0;
         vs_prev_r <= 1'b0;
      end
      else if (v_d_r)
      begin
         vs_prev_r <= vs_d_r;
         if (vs_d_r && !vs_prev_r)
            phase_r <= '0;                          // R08
         else if (de_d_r)
            phase_r <= phase_r + 2'h1;
      end
   end

   // frame sequence bits, resync on link error
   logic [1:0] fseq_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         fseq_r <= '0;
      else if (err_s || (v_d_r && vs_d_r && !vs_prev_r))
         fseq_r <= '0;                              // R14
      else if (v_d_r && !vs_d_r && vs_prev_r)
         fseq_r <= fseq_r + 2'h1;
   end

   // pack word: colour, vs untouched, hs, sequence
   logic [rpsf_pkg::WORD_W-1:0] pix_word;
   logic                        push;
   logic                        buf_rdy;
   logic                        q_valid;
   logic                        q_ready;
   logic [rpsf_pkg::WORD_W-1:0] q_data;
   assign pix_word = {cfg_r[rpsf_pkg::CFG_DITH] ? dith : col,  // R10
                      vs_d_r, hs_d_r, fseq_r};                 // R09
   // active video only, plus vertical sync changes carried blank
   assign push = v_d_r && (de_d_r || vs_d_r != vs_prev_r);     // R17
   rpsf_buf u_buf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (buf_rdy),
      .in_data   (pix_word),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_data)
   );

   // serializer: ten slices of three bits, link clock divider
   logic [2:0]                  div_r;
   logic [3:0]                  slice_r;
   logic                        busy_r;
   logic [rpsf_pkg::WORD_W+1:0] ser_r;
   logic                        tick;
   assign tick    = (div_r == rpsf_pkg::LCLK_HALF) && serial_link_clock;
   assign q_ready = !busy_r && !asleep;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_r             <= '0;
         serial_link_clock <= 1'b0;
      end
      else if (asleep)
      begin
         div_r             <= '0;        // R05
         serial_link_clock <= 1'b0;
      end
      else if (div_r == rpsf_pkg::LCLK_HALF)
      begin
         div_r             <= '0;
         serial_link_clock <= ~serial_link_clock;  // R15
      end
      else
         div_r <= div_r + 3'h1;
   end

   // lane shifter
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_r            <= 1'b0;
         slice_r           <= '0;
         ser_r             <= '0;
         serial_data_lanes <= '0;
      end
      else if (asleep)
      begin
         busy_r            <= 1'b0;
         serial_data_lanes <= '0;
      end
      else if (q_valid && q_ready)
      begin
         busy_r  <= 1'b1;
         slice_r <= '0;
         ser_r   <= {q_data, 2'b00};
      end
      else if (busy_r && tick)
      begin
         serial_data_lanes <= ser_r[rpsf_pkg::WORD_W+1 -: 3]; // R15
         ser_r   <= {ser_r[rpsf_pkg::WORD_W-2:0], 3'b000};
         slice_r <= slice_r + 4'h1;
         busy_r  <= (slice_r != rpsf_pkg::SLICE_LAST);
      end
   end

   // status outputs
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sleeping       <= 1'b1;
         frame_sync_err <= 1'b0;
      end
      else
      begin
         sleeping       <= asleep;
         frame_sync_err <= tm_bad_s || (push && !buf_rdy); // R16
      end
   end
endmodule

/* testbench/rpsf_top_sva.sv */
// rpsf_top_sva: port checks of the serializer front end
// assumes binding onto rpsf_top, pins seen on clk_sys
`timescale 1ns/1ps
module rpsf_top_sva (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // watched pins
   input wire logic       pixel_clk,
   input wire logic       cfg_chip_select_n,
   input wire logic       cfg_data_or_hsync_pin_oe,
   input wire logic       power_down_n,
   input wire logic       test_mode_select,
   input wire logic       reserved_tie_high,
   input wire logic [2:0] serial_data_lanes,
   input wire logic       serial_link_clock,
   input wire logic       sleeping,
   input wire logic       frame_sync_err
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic       pclk_q_r; // last pixel clock level
   logic [9:0] quiet_r;  // cycles since pixel clock moved
   // saturating quiet time of the pixel clock
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pclk_q_r <= 1'b0;
         quiet_r  <= 10'h000;
      end
      else
      begin
         pclk_q_r <= pixel_clk;
         if (pixel_clk != pclk_q_r)
            quiet_r <= 10'h000;
         else if (quiet_r != 10'h3ff)
            quiet_r <= quiet_r + 10'h001;
      end
   end
   a_oe_needs_cs: assert property (
      cfg_chip_select_n [*5] |-> !cfg_data_or_hsync_pin_oe)
      else $error("data pin driven while deselected");
   a_oe_needs_awake: assert property (
      !power_down_n [*5] |-> !cfg_data_or_hsync_pin_oe)
      else $error("data pin driven while asleep");
   a_oe_needs_quiet: assert property (
      $rose(cfg_data_or_hsync_pin_oe) |-> quiet_r >= 10'h186)
      else $error("spi answered with pixel clock running");
   a_sleep_on_pd: assert property (
      !power_down_n [*5] |-> sleeping)
      else $error("not asleep while power down low");
   a_wake_on_pd: assert property (
      $rose(power_down_n) |-> ##[1:8] !sleeping)
      else $error("no wake after power down released");
   a_link_clk_half: assert property (
      !sleeping && $changed(serial_link_clock)
      |=> $stable(serial_link_clock) [*3])
      else $error("link clock half period short");
   a_lanes_on_fall: assert property (
      !sleeping && $changed(serial_data_lanes)
      |-> $fell(serial_link_clock))
      else $error("lanes moved off the link clock fall");
   a_test_mode_err: assert property (
      test_mode_select [*3] |-> ##[0:3] frame_sync_err)
      else $error("test mode not flagged");
   a_reserved_err: assert property (
      !reserved_tie_high [*3] |-> ##[0:3] frame_sync_err)
      else $error("reserved pin low not flagged");
   // main scenarios reached
   c_spi_read: cover property ($rose(cfg_data_or_hsync_pin_oe));
   c_sleep: cover property ($rose(sleeping));
   c_flag: cover property ($rose(frame_sync_err));
endmodule
bind rpsf_top rpsf_top_sva u_sva (
   .clk_sys(clk_sys), .rst_n(rst_n), .pixel_clk(pixel_clk),
   .cfg_chip_select_n(cfg_chip_select_n),
   .cfg_data_or_hsync_pin_oe(cfg_data_or_hsync_pin_oe),
   .power_down_n(power_down_n), .test_mode_select(test_mode_select),
   .reserved_tie_high(reserved_tie_high),
   .serial_data_lanes(serial_data_lanes),
   .serial_link_clock(serial_link_clock), .sleeping(sleeping),
   .frame_sync_err(frame_sync_err));

/* testbench/rpsf_des_model.sv */
// rpsf_des_model: far-end deserializer, gathers lane triples
// assumes lanes settle on the link clock fall
`timescale 1ns/1ps
module rpsf_des_model (
   // link from the serializer
   input wire logic        serial_link_clock,
   input wire logic [2:0]  serial_data_lanes,
   // bench control and view
   input wire logic        win_clr,
   output logic     [29:0] rx_window
);
   // one triple per link clock rise, msb triple first
   always_ff @(posedge serial_link_clock or posedge win_clr)
   begin
      if (win_clr)
         rx_window <= 30'h0000_0000;
      else
         rx_window <= {rx_window[26:0], serial_data_lanes};
   end
endmodule

/* testbench/rpsf_top_test.sv */
// rpsf_top_test: self-checking bench of the serializer front end
// assumes checker and far-end model compiled before it
`timescale 1ns/1ps
module rpsf_top_test;
   logic        clk_sys = 1'b0;   // system clock
   logic        rst_n = 1'b0;     // reset
   logic        pixel_clk = 1'b0; // pixel clock, gated
   logic        pclk_run = 1'b1;  // pixel clock gate
   logic [7:0]  red_in = 8'h00;   // colour pins
   logic [7:0]  green_in = 8'h00;
   logic [7:0]  blue_in = 8'h00;
   logic        vs = 1'b0;        // vertical sync
   logic        de = 1'b0;        // data enable
   logic        hs = 1'b0;        // hsync level
   logic        cs_n = 1'b1;      // chip select
   logic        sclk = 1'b0;      // spi clock
   logic        sda = 1'b0;       // host data bit
   logic        pd_n = 1'b1;      // power down
   logic        tm = 1'b0;        // test mode
   logic        res_hi = 1'b1;    // reserved pin
   logic        lerr = 1'b0;      // link error
   logic        win_clr = 1'b0;   // far-end window clear
   wire logic   pin_i;            // resolved data pin
   logic        pin_o, pin_oe;    // design pin drive
   logic        slc, sleeping, fse;
   logic [2:0]  lanes;
   logic [29:0] rx_win;
   logic [7:0]  rd;
   logic [23:0] lut_val = 24'h9c3c5c; // corrected colour per table
   logic        oe_seen, hit;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          k;
   // ordinary pixels: r, g, b, vs, hs; cfg clear passes them as is
   logic [25:0] rows [0:3] = '{{8'h80, 8'h01, 8'hff, 2'b01},
      {8'h12, 8'h34, 8'h56, 2'b10}, {8'h00, 8'hff, 8'h00, 2'b11},
      {8'ha5, 8'h5a, 8'hc3, 2'b00}};
   // device drives the pin only with enable high
   assign pin_i = pin_oe ? pin_o : (cs_n ? hs : sda);
   always #2.5 clk_sys = ~clk_sys;
   // 125 ns pixel clock, off phase from clk_sys
   initial
   begin
      #0.7;
      forever #62.5 if (pclk_run) pixel_clk = ~pixel_clk;
   end
   rpsf_top dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .pixel_clk(pixel_clk), .red_in(red_in), .green_in(green_in),
      .blue_in(blue_in), .vertical_sync(vs), .video_data_enable(de),
      .cfg_chip_select_n(cs_n), .cfg_spi_clk(sclk),
      .cfg_data_or_hsync_pin_i(pin_i), .cfg_data_or_hsync_pin_o(pin_o),
      .cfg_data_or_hsync_pin_oe(pin_oe), .power_down_n(pd_n),
      .test_mode_select(tm), .reserved_tie_high(res_hi),
      .link_error(lerr), .serial_data_lanes(lanes),
      .serial_link_clock(slc), .sleeping(sleeping),
      .frame_sync_err(fse));
   rpsf_des_model u_des (.serial_link_clock(slc),
      .serial_data_lanes(lanes), .win_clr(win_clr), .rx_window(rx_win));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one active pixel, then search the far-end window
   task automatic video(input logic [25:0] px, input logic [29:0] exp,
                        input logic [29:0] msk);
      hit = 1'b0;
      @(negedge pixel_clk);
      tick(1);
      {red_in, green_in, blue_in, vs, hs} = px;
      de = 1'b1;
      win_clr = 1'b1;
      tick(1);
      win_clr = 1'b0;
      @(negedge pixel_clk);
      tick(1);
      de = 1'b0;
      repeat (400)
      begin
         tick(1);
         if ((rx_win & msk) === (exp & msk))
            hit = 1'b1;
      end
   endtask
   // 24-bit spi frame, msb first; stop parks the pixel clock
   task automatic spi(input logic [23:0] c, input logic stop);
      oe_seen = 1'b0;
      if (stop)
      begin
         @(negedge pixel_clk);
         pclk_run = 1'b0;
         tick(450);
      end
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         sda = c[i];
         tick(20);
         sclk = 1'b1;
         oe_seen = oe_seen | pin_oe;
         rd = {rd[6:0], pin_o};
         tick(20);
         sclk = 1'b0;
      end
      tick(20);
      cs_n = 1'b1;
      tick(10);
      pclk_run = 1'b1;
   endtask
   function automatic logic [23:0] cmd(input logic r, input logic [1:0] t,
                                       input logic [7:0] a, d);
      return {r, t, 5'h00, a, d};
   endfunction
   initial
   begin
      tick(6);
      chk(8'(sleeping), 8'h01);
      chk(8'(pin_oe), 8'h00);
      rst_n = 1'b1;
      tick(20);
      chk(8'(sleeping), 8'h00);
      for (k = 0; k < 4; k++)
      begin
         video(rows[k], {rows[k], 4'h0}, 30'h3fff_fff3);
         chk(8'(hit), 8'h01);
      end
      spi(cmd(1'b1, rpsf_pkg::TGT_CFG, 8'h00, 8'h00), 1'b0);
      chk(8'(oe_seen), 8'h00);
      spi(cmd(1'b0, rpsf_pkg::TGT_CFG, 8'h00, 8'h02), 1'b1);
      spi(cmd(1'b1, rpsf_pkg::TGT_CFG, 8'h00, 8'h00), 1'b1);
      chk(rd, 8'h02);
      chk(8'(oe_seen), 8'h01);
      // dither: low bits cleared, top nibble kept
      video({8'h41, 8'h81, 8'hc1, 2'b11}, {8'h40, 8'h80, 8'hc0, 6'h30},
            {8'hf3, 8'hf3, 8'hf3, 6'h33});
      chk(8'(hit), 8'h01);
      for (k = 1; k < 4; k++)
         spi(cmd(1'b0, 2'(k), rows[1][33-8*k -: 8],
             lut_val[31-8*k -: 8]), 1'b1);
      spi(cmd(1'b0, rpsf_pkg::TGT_CFG, 8'h00, 8'h01), 1'b1);
      video(rows[1], {24'h9c3c5c, 6'h20}, 30'h3fff_fff3);
      chk(8'(hit), 8'h01);
      // auto sleep: set while the pixel clock is parked
      spi(cmd(1'b0, rpsf_pkg::TGT_CFG, 8'h00, 8'h05), 1'b1);
      chk(8'(sleeping), 8'h01);
      tick(40);
      chk(8'(sleeping), 8'h00);
      pd_n = 1'b0;
      tick(20);
      chk(8'(sleeping), 8'h01);
      spi(cmd(1'b1, rpsf_pkg::TGT_CFG, 8'h00, 8'h00), 1'b1);
      chk(8'(oe_seen), 8'h00);
      pd_n = 1'b1;
      tick(20);
      chk(8'(sleeping), 8'h00);
      spi(cmd(1'b1, rpsf_pkg::TGT_CFG, 8'h00, 8'h00), 1'b1);
      chk(rd, 8'h00);
      spi(cmd(1'b0, rpsf_pkg::TGT_CFG, 8'h00, 8'h01), 1'b1);
      vs = 1'b0; // sync fall steps the sequence to one
      tick(200);
      lerr = 1'b1;
      tick(4);
      lerr = 1'b0;
      video({rows[1][25:2], 2'b00}, {24'h9c3c5c, 6'h00}, 30'h3fff_ffff);
      chk(8'(hit), 8'h01);
      tm = 1'b1;
      tick(10);
      chk(8'(fse), 8'h01);
      tm = 1'b0;
      res_hi = 1'b0;
      tick(10);
      chk(8'(fse), 8'h01);
      res_hi = 1'b1;
      give_verdict();
   end
endmodule
